// *** hw/stc_regs.svh ***
// Register offsets, field positions and reset values of the self-test controls
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
`define STC_IDX_TEST_CONTROL 8'h20
`define STC_IDX_ADC_OUTPUT_TEST 8'h22
`define STC_IDX_AUX_PULLUP 8'h25
`define STC_IDX_IRQ_STATUS 8'h30
`define STC_IDX_IRQ_MASK 8'h31
`define STC_ADDR_TEST_CONTROL 8'h80
`define STC_ADDR_ADC_OUTPUT_TEST 8'h88
`define STC_ADDR_AUX_PULLUP 8'h94
`define STC_ADDR_IRQ_STATUS 8'hc0
`define STC_ADDR_IRQ_MASK 8'hc4
`define STC_TC_ECC_HI 7
`define STC_TC_ECC_LO 5
`define STC_TC_FULL_CAL 4
`define STC_TC_PART_CAL 3
`define STC_TC_DIG_TRIP 2
`define STC_TC_ANA_TRIP 1
`define STC_TC_PROT_TRIP 0
`define STC_AT_SUBST_EN 23
`define STC_AT_VALUE_HI 13
`define STC_AT_VALUE_LO 0
`define STC_ECC_MAX_CODE 3'h4
`define STC_IRQ_CAL_DONE 0
`define STC_IRQ_CAL_FAIL 1
`define STC_IRQ_PART_DROP 2
`define STC_IRQ_ECC_INJECT 3
`define STC_IRQ_WIDTH 4
`define STC_RST_ECC 3'h0
`define STC_RST_SUBST 14'h0000
`define STC_RST_PULLUP 8'h00
`define STC_RST_IRQ 4'h0
`endif

// *** hw/stc_pkg.sv ***
// Types shared by the self-test control block
`default_nettype none
package stc_pkg;
  typedef enum logic [1:0] {
    STC_CAL_IDLE,
    STC_CAL_FULL,
    STC_CAL_PART
  } stc_cal_state_type;
  typedef struct packed {
    logic valid;
    logic [13:0] value;
  } stc_sample_type;
  typedef struct packed {
    logic start;
    logic full;
    logic abort;
  } stc_cal_req_type;
  typedef struct packed {
    logic done;
    logic fail;
  } stc_cal_rsp_type;
  typedef struct packed {
    logic inject;
    logic [2:0] code;
  } stc_ecc_req_type;
endpackage : stc_pkg
`default_nettype wire

// *** hw/stc_ctrl.sv ***
// Self-test control register set with APB slave and interrupt
// Functional notes
// - Test control bits 15 to 10 read as zero.
// - Error injection codes 1-4 load user or vendor errors, 0 and 5-7 do nothing.
// - Writing one to the full calibration bit starts a full test, outcome to the fault register.
// - Calibration trigger bits read one while running and zero when done.
// - A full request during a partial test aborts it, clears it and starts full.
// - A partial request while full is set is ignored and its bit cleared.
// - A partial test runs short and never overwrites stored factory results.
// - The digital-die thermal trip bit forces that shutdown and a reset.
// - The analog-die thermal trip bit forces that shutdown and a reset.
// - The protection-check bit simulates the check, power-down and reset.
// - With substitution enabled conversions run but results take the programmed value.
// - The substitute value is 14-bit two's complement.
// - Trim is still applied downstream to the substitute value.
// - ADC output test bits 22 to 14 are reserved and 19 to 14 read zero.
// - One pull-up enable per auxiliary input, bit zero for the first.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stc_regs.svh"
module stc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output stc_pkg::stc_cal_req_type cal_req,
  input wire stc_pkg::stc_cal_rsp_type cal_rsp,
  input wire logic cal_store_req,
  output logic cal_store_we,
  output logic cal_err_update,
  output logic cal_err_value,
  output stc_pkg::stc_ecc_req_type ecc_req,
  output logic digital_die_thermal_trip,
  output logic analog_die_thermal_trip,
  output logic protection_check_trip,
  input wire stc_pkg::stc_sample_type adc_raw,
  output stc_pkg::stc_sample_type adc_pre_trim,
  output logic [7:0] aux_pullup_en,
  output logic irq
);
  import stc_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic hit_tc = paddr == `STC_ADDR_TEST_CONTROL;
  wire logic hit_at = paddr == `STC_ADDR_ADC_OUTPUT_TEST;
  wire logic hit_pu = paddr == `STC_ADDR_AUX_PULLUP;
  wire logic hit_is = paddr == `STC_ADDR_IRQ_STATUS;
  wire logic hit_im = paddr == `STC_ADDR_IRQ_MASK;
  wire logic hit_any = hit_tc || hit_at || hit_pu || hit_is || hit_im;
  wire logic wr_tc = wr && hit_tc;
  wire logic wr_at = wr && hit_at;
  wire logic wr_pu = wr && hit_pu;
  wire logic wr_is = wr && hit_is;
  wire logic wr_im = wr && hit_im;

  // Zero wait states keep the slave trivially predictable
  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  stc_cal_state_type cal_reg, cal_next;
  logic [2:0] ecc_reg;
  logic dig_trip_reg, ana_trip_reg, prot_trip_reg;
  logic subst_en_reg;
  logic [13:0] subst_reg;
  logic [7:0] pullup_reg;
  logic [`STC_IRQ_WIDTH-1:0] irq_sts_reg, irq_sts_next, irq_mask_reg;
  stc_cal_req_type cal_req_reg, cal_req_next;
  stc_ecc_req_type ecc_req_reg;
  stc_sample_type out_reg;
  logic err_upd_reg, err_val_reg;

  function automatic logic ecc_valid(input logic [2:0] code);
    ecc_valid = code != 3'h0 && code <= `STC_ECC_MAX_CODE;
  endfunction : ecc_valid

  // ----------------------------------------
  // Calibration arbitration
  // ----------------------------------------
  wire logic req_full = wr_tc && pwdata[`STC_TC_FULL_CAL];
  wire logic req_part = wr_tc && pwdata[`STC_TC_PART_CAL];
  wire logic cal_busy = cal_reg != STC_CAL_IDLE;
  wire logic cal_end = cal_busy && cal_rsp.done;
  // Partial refused while full runs or is requested in the same write
  wire logic part_drop = req_part && (cal_reg == STC_CAL_FULL || req_full);
  wire logic part_abort = req_full && cal_reg == STC_CAL_PART;

  always_comb begin
    cal_next = cal_reg;
    cal_req_next = '0;
    if (cal_end) begin
      cal_next = STC_CAL_IDLE;
    end
    if (req_full && cal_reg != STC_CAL_FULL) begin
      cal_next = STC_CAL_FULL;
      cal_req_next.start = 1'b1;
      cal_req_next.full = 1'b1;
      cal_req_next.abort = part_abort;
    end else if (req_part && !part_drop && cal_reg == STC_CAL_IDLE) begin
      cal_next = STC_CAL_PART;
      cal_req_next.start = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_reg <= STC_CAL_IDLE;
      cal_req_reg <= '0;
    end else begin
      cal_reg <= cal_next;
      cal_req_reg <= cal_req_next;
    end
  end

  assign cal_req = cal_req_reg;
  // Factory results stay untouched by a partial test
  assign cal_store_we = cal_store_req && cal_reg == STC_CAL_FULL;

  // Outcome reported to the device fault register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_upd_reg <= 1'b0;
      err_val_reg <= 1'b0;
    end else begin
      err_upd_reg <= cal_end && cal_reg == STC_CAL_FULL;
      if (cal_end && cal_reg == STC_CAL_FULL) begin
        err_val_reg <= cal_rsp.fail;
      end
    end
  end

  assign cal_err_update = err_upd_reg;
  assign cal_err_value = err_val_reg;

  // ----------------------------------------
  // Test control, trips and error injection
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_reg <= `STC_RST_ECC;
      dig_trip_reg <= 1'b0;
      ana_trip_reg <= 1'b0;
      prot_trip_reg <= 1'b0;
      ecc_req_reg <= '0;
    end else begin
      ecc_req_reg.inject <= wr_tc && ecc_valid(pwdata[`STC_TC_ECC_HI:`STC_TC_ECC_LO]);
      if (wr_tc) begin
        ecc_reg <= pwdata[`STC_TC_ECC_HI:`STC_TC_ECC_LO];
        ecc_req_reg.code <= pwdata[`STC_TC_ECC_HI:`STC_TC_ECC_LO];
        dig_trip_reg <= pwdata[`STC_TC_DIG_TRIP];
        ana_trip_reg <= pwdata[`STC_TC_ANA_TRIP];
        prot_trip_reg <= pwdata[`STC_TC_PROT_TRIP];
      end
    end
  end

  assign ecc_req = ecc_req_reg;
  assign digital_die_thermal_trip = dig_trip_reg;
  assign analog_die_thermal_trip = ana_trip_reg;
  assign protection_check_trip = prot_trip_reg;

  // ----------------------------------------
  // ADC output substitution and pull-ups
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subst_en_reg <= 1'b0;
      subst_reg <= `STC_RST_SUBST;
      pullup_reg <= `STC_RST_PULLUP;
    end else begin
      if (wr_at) begin
        subst_en_reg <= pwdata[`STC_AT_SUBST_EN];
        subst_reg <= pwdata[`STC_AT_VALUE_HI:`STC_AT_VALUE_LO];
      end
      if (wr_pu) begin
        pullup_reg <= pwdata[7:0];
      end
    end
  end

  // Conversion timing is kept; only the value is replaced before trim
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= '0;
    end else begin
      out_reg.valid <= adc_raw.valid;
      if (adc_raw.valid) begin
        out_reg.value <= subst_en_reg ? subst_reg : adc_raw.value;
      end
    end
  end

  assign adc_pre_trim = out_reg;
  assign aux_pullup_en = pullup_reg;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire logic [`STC_IRQ_WIDTH-1:0] irq_evt = {
    ecc_req_reg.inject, part_drop, cal_end && cal_rsp.fail, cal_end};

  // Set beats a simultaneous write-one clear
  always_comb begin
    irq_sts_next = irq_sts_reg;
    if (wr_is) begin
      irq_sts_next = irq_sts_reg & ~pwdata[`STC_IRQ_WIDTH-1:0];
    end
    irq_sts_next = irq_sts_next | irq_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_reg <= `STC_RST_IRQ;
      irq_mask_reg <= `STC_RST_IRQ;
    end else begin
      irq_sts_reg <= irq_sts_next;
      if (wr_im) begin
        irq_mask_reg <= pwdata[`STC_IRQ_WIDTH-1:0];
      end
    end
  end

  assign irq = |(irq_sts_reg & irq_mask_reg);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire logic [15:0] tc_rd = {6'h00, 2'h0, ecc_reg,
    cal_reg == STC_CAL_FULL, cal_reg == STC_CAL_PART,
    dig_trip_reg, ana_trip_reg, prot_trip_reg};
  wire logic [23:0] at_rd = {subst_en_reg, 3'h0, 6'h00, subst_reg};

  logic [31:0] rd_mux, rd_data_reg;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_tc) begin
      rd_mux = {16'h0000, tc_rd};
    end else if (hit_at) begin
      rd_mux = {8'h00, at_rd};
    end else if (hit_pu) begin
      rd_mux = {24'h00_0000, pullup_reg};
    end else if (hit_is) begin
      rd_mux = {28'h000_0000, irq_sts_reg};
    end else if (hit_im) begin
      rd_mux = {28'h000_0000, irq_mask_reg};
    end
  end

  // Captured in the setup phase; a status bit set in that cycle shows on the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rd_data_reg <= rd_mux;
    end
  end

  assign prdata = rd_data_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_full_start;
    req_full && cal_reg != STC_CAL_FULL |=> cal_reg == STC_CAL_FULL && cal_req.start && cal_req.full;
  endproperty
  a_full_start: assert property (p_full_start) else $error("full test not started");

  property p_self_clear;
    cal_busy && cal_rsp.done && !req_full |=> cal_reg == STC_CAL_IDLE;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("trigger bit not cleared");

  property p_abort;
    req_full && cal_reg == STC_CAL_PART |=> cal_req.abort && cal_reg == STC_CAL_FULL;
  endproperty
  a_abort: assert property (p_abort) else $error("partial not aborted");

  property p_ignore_part;
    cal_reg == STC_CAL_FULL && req_part && !cal_rsp.done |=> cal_reg == STC_CAL_FULL
      && !cal_req.start;
  endproperty
  a_ignore_part: assert property (p_ignore_part) else $error("partial not ignored");

  property p_no_overwrite;
    cal_reg == STC_CAL_PART |-> !cal_store_we;
  endproperty
  a_no_overwrite: assert property (p_no_overwrite) else $error("factory store written");

  property p_trip;
    wr_tc |=> digital_die_thermal_trip == $past(pwdata[2])
      && analog_die_thermal_trip == $past(pwdata[1]) && protection_check_trip == $past(pwdata[0]);
  endproperty
  a_trip: assert property (p_trip) else $error("trip bit mismatch");

  property p_subst;
    adc_raw.valid && subst_en_reg && !wr_at |=> adc_pre_trim.valid
      && adc_pre_trim.value == subst_reg;
  endproperty
  a_subst: assert property (p_subst) else $error("substitute value not used");

  property p_reserved;
    acc && (hit_tc || hit_at) |-> prdata[31:24] == 8'h00 && (hit_at ?
      prdata[22:14] == 9'h000 : prdata[15:8] == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_ecc;
    wr_tc && pwdata[7:5] > 3'h4 |=> !ecc_req.inject;
  endproperty
  a_ecc: assert property (p_ecc) else $error("reserved code injected");

  property p_pullup;
    wr_pu |=> aux_pullup_en == $past(pwdata[7:0]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up mismatch");

  property p_part_start;
    req_part && !req_full && cal_reg == STC_CAL_IDLE |=> cal_reg == STC_CAL_PART
      && cal_req.start && !cal_req.full;
  endproperty
  a_part_start: assert property (p_part_start) else $error("partial test not started");

  property p_drop;
    part_drop |=> cal_reg != STC_CAL_PART && !(cal_req.start && !cal_req.full);
  endproperty
  a_drop: assert property (p_drop) else $error("refused partial test started");

  property p_err_report;
    cal_end && cal_reg == STC_CAL_FULL |=> cal_err_update
      && cal_err_value == $past(cal_rsp.fail);
  endproperty
  a_err_report: assert property (p_err_report) else $error("full test outcome lost");

  property p_read_state;
    psel && !penable && hit_tc |=> prdata[4:3]
      == $past({cal_reg == STC_CAL_FULL, cal_reg == STC_CAL_PART});
  endproperty
  a_read_state: assert property (p_read_state) else $error("trigger readback wrong");

  property p_pass_raw;
    adc_raw.valid && !subst_en_reg |=> adc_pre_trim.valid
      && adc_pre_trim.value == $past(adc_raw.value);
  endproperty
  a_pass_raw: assert property (p_pass_raw) else $error("raw conversion not passed");

  property p_ecc_inject;
    wr_tc && pwdata[7:5] != 3'h0 && pwdata[7:5] <= 3'h4 |=> ecc_req.inject
      && ecc_req.code == $past(pwdata[7:5]);
  endproperty
  a_ecc_inject: assert property (p_ecc_inject) else $error("error injection missed");

  // Set must beat a write-one clear in the same cycle
  property p_set_wins;
    wr_is && cal_end |=> irq_sts_reg[`STC_IRQ_CAL_DONE];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost to clear");

  c_full_run: cover property (req_full ##[1:50] cal_end);
  c_abort: cover property (cal_reg == STC_CAL_PART ##1 req_full);
  c_drop: cover property (part_drop);
  c_irq: cover property ($rose(irq));
  c_subst: cover property (adc_raw.valid && subst_en_reg);
endmodule : stc_ctrl
`default_nettype wire

// *** verif/stc_ctrl_test.sv ***
// Self-checking bench for the self-test control register set
`timescale 1ns/1ps
`default_nettype none
`include "stc_regs.svh"
module stc_ctrl_test;
  import stc_pkg::*;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, cal_store_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, cal_store_we, cal_err_update, cal_err_value, irq, err;
  logic dig_trip, ana_trip, prot_trip;
  logic [7:0] aux_pullup_en;
  stc_cal_req_type cal_req;
  stc_cal_rsp_type cal_rsp;
  stc_ecc_req_type ecc_req;
  stc_sample_type adc_raw, adc_pre_trim;
  int bad_count, num_checks;
  logic [7:0] rst_addr [0:4] = '{`STC_ADDR_TEST_CONTROL, `STC_ADDR_ADC_OUTPUT_TEST,
    `STC_ADDR_AUX_PULLUP, `STC_ADDR_IRQ_STATUS, `STC_ADDR_IRQ_MASK};
  logic [13:0] subst [0:2] = '{14'h2000, 14'h1fff, 14'h0000};
  stc_ctrl dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_req(cal_req), .cal_rsp(cal_rsp), .cal_store_req(cal_store_req),
    .cal_store_we(cal_store_we), .cal_err_update(cal_err_update),
    .cal_err_value(cal_err_value), .ecc_req(ecc_req), .digital_die_thermal_trip(dig_trip),
    .analog_die_thermal_trip(ana_trip), .protection_check_trip(prot_trip),
    .adc_raw(adc_raw), .adc_pre_trim(adc_pre_trim), .aux_pullup_en(aux_pullup_en), .irq(irq)
  );
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Holds the request until pready is seen; no fixed wait assumed
  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb_xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb_xfer(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rd_chk
  task automatic cal_done(input logic f);
    @(posedge pclk);
    cal_rsp <= '{done: 1'b1, fail: f};
    @(posedge pclk);
    cal_rsp <= '0;
    #1;
    chk("cal err update", 32'h1, {31'h0, cal_err_update});
    chk("cal err value", {31'h0, f}, {31'h0, cal_err_value});
  endtask : cal_done
  task automatic adc_pulse(input logic [13:0] v, input logic [13:0] exp);
    @(posedge pclk);
    adc_raw <= '{valid: 1'b1, value: v};
    @(posedge pclk);
    adc_raw <= '0;
    #1;
    chk("adc pre trim", {17'h1, exp}, {17'h0, adc_pre_trim});
  endtask : adc_pulse
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, cal_store_req} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cal_rsp = '0;
    adc_raw = '0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_addr[i]) rd_chk(rst_addr[i], 32'h0, "reset value");
    apb_xfer(1'b0, 8'h84, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    // One trip at a time; bits 9 and 8 written as ones must not read back
    for (int t = 0; t < 3; t++) begin
      wr(`STC_ADDR_TEST_CONTROL, 32'h0000_0300 | (32'h1 << t));
      chk("trip", 32'h1 << t, {29'h0, dig_trip, ana_trip, prot_trip});
      rd_chk(`STC_ADDR_TEST_CONTROL, 32'h1 << t, "reserved zero");
    end
    wr(`STC_ADDR_TEST_CONTROL, 32'h0);
    chk("trips clear", 32'h0, {29'h0, dig_trip, ana_trip, prot_trip});
    // Every code, reserved ones too, must leave no stray injection
    for (int c = 0; c < 8; c++) begin
      wr(`STC_ADDR_TEST_CONTROL, 32'(c) << 5);
      chk("ecc inject", 32'(c >= 1 && c <= 4), {31'h0, ecc_req.inject});
      if (c >= 1 && c <= 4) chk("ecc code", 32'(c), {29'h0, ecc_req.code});
      rd_chk(`STC_ADDR_TEST_CONTROL, 32'(c) << 5, "ecc readback");
    end
    rd_chk(`STC_ADDR_IRQ_STATUS, 32'h8, "ecc status");
    wr(`STC_ADDR_IRQ_STATUS, 32'h8);
    rd_chk(`STC_ADDR_IRQ_STATUS, 32'h0, "status clear");
    wr(`STC_ADDR_IRQ_MASK, 32'hf);
    rd_chk(`STC_ADDR_IRQ_MASK, 32'hf, "mask readback");
    cal_store_req <= 1'b1;
    wr(`STC_ADDR_TEST_CONTROL, 32'h10);
    chk("full request", 32'h6, {29'h0, cal_req});
    chk("full store", 32'h1, {31'h0, cal_store_we});
    rd_chk(`STC_ADDR_TEST_CONTROL, 32'h10, "full running");
    cal_done(1'b1);
    rd_chk(`STC_ADDR_TEST_CONTROL, 32'h0, "full done");
    chk("irq raised", 32'h1, {31'h0, irq});
    rd_chk(`STC_ADDR_IRQ_STATUS, 32'h3, "full status");
    wr(`STC_ADDR_IRQ_STATUS, 32'h3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(`STC_ADDR_TEST_CONTROL, 32'h08);
    chk("partial request", 32'h4, {29'h0, cal_req});
    chk("partial store", 32'h0, {31'h0, cal_store_we});
    rd_chk(`STC_ADDR_TEST_CONTROL, 32'h08, "partial running");
    wr(`STC_ADDR_TEST_CONTROL, 32'h10);
    chk("abort request", 32'h7, {29'h0, cal_req});
    rd_chk(`STC_ADDR_TEST_CONTROL, 32'h10, "abort state");
    wr(`STC_ADDR_TEST_CONTROL, 32'h08);
    chk("dropped request", 32'h0, {29'h0, cal_req});
    rd_chk(`STC_ADDR_TEST_CONTROL, 32'h10, "dropped state");
    rd_chk(`STC_ADDR_IRQ_STATUS, 32'h4, "dropped status");
    cal_done(1'b0);
    rd_chk(`STC_ADDR_TEST_CONTROL, 32'h0, "abort done");
    wr(`STC_ADDR_IRQ_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`STC_ADDR_IRQ_MASK, 32'h4);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wr(`STC_ADDR_IRQ_STATUS, 32'h5);
    chk("irq w1c", 32'h0, {31'h0, irq});
    adc_pulse(14'h0123, 14'h0123);
    // Substitute values at both ends of the range and mid-range
    foreach (subst[i]) begin
      wr(`STC_ADDR_ADC_OUTPUT_TEST, 32'h0080_0000 | subst[i]);
      rd_chk(`STC_ADDR_ADC_OUTPUT_TEST, 32'h0080_0000 | subst[i], "subst readback");
      adc_pulse(14'h0123, subst[i]);
    end
    wr(`STC_ADDR_AUX_PULLUP, 32'ha5);
    chk("pullup out", 32'ha5, {24'h0, aux_pullup_en});
    rd_chk(`STC_ADDR_AUX_PULLUP, 32'ha5, "pullup readback");
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_sim();
  end
endmodule : stc_ctrl_test
`default_nettype wire
